// File: core/edmac_channel.sv
// Behaviour
// - Source pointer writable, advances per transfer
// - Destination pointer writable, advances per transfer
// - Counter drops by access size per transfer
// - Byte mode: counter drops by one
// - Activation flag gates all transfers
// - Mode bit selects dual or single address
// - Mode select 00 runs normal auto transfer
// - Size bit selects byte or word
// - Source update 10 increments source
// - Destination update 10 increments destination
// - Auto request: starts when software activates
`timescale 1ns/1ps
`default_nettype none

module edmac_channel (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_ack,
    input  wire logic [15:0] ext_rdata,
    output logic      [31:0] ext_addr,
    output logic      [15:0] ext_wdata,
    output logic             ext_rd,
    output logic             ext_wr,
    output logic             ext_word,
    output logic             ext_bus_own,
    output logic             ext_dack
);
    import edmac_pkg::*;

    logic [31:0]  prdata_reg,  prdata_next;
    logic         pready_reg,  pready_next;
    logic         pslverr_reg, pslverr_next;
    logic [31:0]  src_reg,     src_next;
    logic [31:0]  dst_reg,     dst_next;
    logic [31:0]  cnt_reg,     cnt_next;
    logic [15:0]  mode_reg,    mode_next;
    logic [15:0]  upd_reg,     upd_next;
    logic [15:0]  data_reg,    data_next;
    logic [31:0]  addr_reg,    addr_next;
    logic         rd_reg,      rd_next;
    logic         wr_reg,      wr_next;
    logic         word_reg,    word_next;
    logic         own_reg,     own_next;
    logic         dack_reg,    dack_next;
    edmac_state_e state_reg,   state_next;

    logic [16:0]  pin_sync;
    logic         ack_sync;
    logic [15:0]  rdata_sync;
    logic         hit_src, hit_dst, hit_cnt, hit_mode, hit_upd, hit_any;
    logic         sw_wr;
    logic [31:0]  step;
    logic [1:0]   src_upd, dst_upd, msel;
    logic         single_addr;

    // Acknowledge and read data come from pins
    edmac_pin_sync #(
        .WIDTH    (17)
    ) u_pin_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in ({ext_ack, ext_rdata}),
        .sync_out (pin_sync)
    );

    assign ack_sync   = pin_sync[16];
    assign rdata_sync = pin_sync[15:0];

    // Address decode
    assign hit_src  = (paddr == edmac_reg_addr(EDMAC_IDX_SRC));
    assign hit_dst  = (paddr == edmac_reg_addr(EDMAC_IDX_DST));
    assign hit_cnt  = (paddr == edmac_reg_addr(EDMAC_IDX_CNT));
    assign hit_mode = (paddr == edmac_reg_addr(EDMAC_IDX_MODE));
    assign hit_upd  = (paddr == edmac_reg_addr(EDMAC_IDX_UPD));
    assign hit_any  = hit_src | hit_dst | hit_cnt | hit_mode | hit_upd;
    // Writes land only on the completing edge
    assign sw_wr    = psel & penable & pwrite & pready_reg;

    // Field views
    assign step        = mode_reg[EDMAC_SIZE_BIT] ? EDMAC_STEP_WORD : EDMAC_STEP_BYTE;
    assign src_upd     = upd_reg[EDMAC_SRCU_HI:EDMAC_SRCU_LO];
    assign dst_upd     = upd_reg[EDMAC_DSTU_HI:EDMAC_DSTU_LO];
    assign msel        = mode_reg[EDMAC_MSEL_HI:EDMAC_MSEL_LO];
    assign single_addr = mode_reg[EDMAC_SINGLE_BIT];

    // Bus slave: one wait state so read data is registered
    always_comb
    begin
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        pready_next  = 1'b0;
        if (psel && penable && !pready_reg)
        begin
            pready_next  = 1'b1;
            pslverr_next = !hit_any;
            unique case (1'b1)
                hit_src:  prdata_next = src_reg;
                hit_dst:  prdata_next = dst_reg;
                hit_cnt:  prdata_next = cnt_reg;
                hit_mode: prdata_next = {16'h0000, mode_reg};
                hit_upd:  prdata_next = {16'h0000, upd_reg};
                default:  prdata_next = EDMAC_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= EDMAC_RST_WORD;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Channel sequencer, then software writes on top
    always_comb
    begin
        src_next   = src_reg;
        dst_next   = dst_reg;
        cnt_next   = cnt_reg;
        mode_next  = mode_reg;
        upd_next   = upd_reg;
        data_next  = data_reg;
        addr_next  = addr_reg;
        rd_next    = rd_reg;
        wr_next    = wr_reg;
        word_next  = word_reg;
        own_next   = own_reg;
        dack_next  = dack_reg;
        state_next = state_reg;
        unique case (state_reg)
            EDMAC_IDLE:
            begin
                // No request pin: activation alone starts it
                if (mode_reg[EDMAC_ACT_BIT] && msel == EDMAC_MSEL_NORMAL)
                begin
                    if (cnt_reg == EDMAC_RST_WORD)
                    begin
                        mode_next[EDMAC_ACT_BIT] = 1'b0;
                    end
                    else
                    begin
                        state_next = EDMAC_RD;
                        rd_next    = 1'b1;
                        own_next   = 1'b1;
                        dack_next  = single_addr;
                        addr_next  = src_reg;
                        word_next  = mode_reg[EDMAC_SIZE_BIT];
                    end
                end
            end
            EDMAC_RD:
            begin
                if (ack_sync)
                begin
                    data_next  = rdata_sync;
                    rd_next    = 1'b0;
                    state_next = EDMAC_RD_END;
                end
            end
            EDMAC_RD_END:
            begin
                // Four-phase: wait for acknowledge to drop
                if (!ack_sync)
                begin
                    if (single_addr)
                    begin
                        own_next   = 1'b0;
                        dack_next  = 1'b0;
                        state_next = EDMAC_STEP;
                    end
                    else
                    begin
                        wr_next    = 1'b1;
                        addr_next  = dst_reg;
                        state_next = EDMAC_WR;
                    end
                end
            end
            EDMAC_WR:
            begin
                if (ack_sync)
                begin
                    wr_next    = 1'b0;
                    state_next = EDMAC_WR_END;
                end
            end
            EDMAC_WR_END:
            begin
                if (!ack_sync)
                begin
                    own_next   = 1'b0;
                    state_next = EDMAC_STEP;
                end
            end
            EDMAC_STEP:
            begin
                // Cycle steal: bus is already given back here
                src_next   = edmac_next_addr(src_reg, src_upd, step);
                dst_next   = edmac_next_addr(dst_reg, dst_upd, step);
                // Short tail saturates rather than wrapping
                cnt_next   = (cnt_reg > step) ? cnt_reg - step : EDMAC_RST_WORD;
                if (cnt_reg <= step)
                begin
                    mode_next[EDMAC_ACT_BIT] = 1'b0;
                end
                state_next = EDMAC_IDLE;
            end
        endcase
        // Software write wins over the same-cycle hardware update
        if (sw_wr && hit_src)
        begin
            src_next = pwdata;
        end
        if (sw_wr && hit_dst)
        begin
            dst_next = pwdata;
        end
        if (sw_wr && hit_cnt)
        begin
            cnt_next = pwdata;
        end
        if (sw_wr && hit_mode)
        begin
            mode_next = pwdata[15:0] & EDMAC_MODE_MASK;
        end
        if (sw_wr && hit_upd)
        begin
            upd_next = pwdata[15:0] & EDMAC_UPD_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_reg   <= EDMAC_RST_WORD;
            dst_reg   <= EDMAC_RST_WORD;
            cnt_reg   <= EDMAC_RST_WORD;
            mode_reg  <= EDMAC_RST_HALF;
            upd_reg   <= EDMAC_RST_HALF;
            data_reg  <= EDMAC_RST_HALF;
            addr_reg  <= EDMAC_RST_WORD;
            rd_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            word_reg  <= 1'b0;
            own_reg   <= 1'b0;
            dack_reg  <= 1'b0;
            state_reg <= EDMAC_IDLE;
        end
        else
        begin
            src_reg   <= src_next;
            dst_reg   <= dst_next;
            cnt_reg   <= cnt_next;
            mode_reg  <= mode_next;
            upd_reg   <= upd_next;
            data_reg  <= data_next;
            addr_reg  <= addr_next;
            rd_reg    <= rd_next;
            wr_reg    <= wr_next;
            word_reg  <= word_next;
            own_reg   <= own_next;
            dack_reg  <= dack_next;
            state_reg <= state_next;
        end
    end

    // All outputs straight from flops
    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign ext_addr    = addr_reg;
    assign ext_wdata   = data_reg;
    assign ext_rd      = rd_reg;
    assign ext_wr      = wr_reg;
    assign ext_word    = word_reg;
    assign ext_bus_own = own_reg;
    assign ext_dack    = dack_reg;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_step_plain;
        state_reg == EDMAC_STEP && !sw_wr;
    endsequence

    sequence s_read_done;
        state_reg == EDMAC_RD_END && !ack_sync;
    endsequence

    AST_SRC_INC: assert property (s_step_plain ##0 src_upd == EDMAC_UPD_INC
        |=> src_reg == $past(src_reg) + $past(step))
        else $error("source pointer did not increment");

    AST_DST_INC: assert property (s_step_plain ##0 dst_upd == EDMAC_UPD_INC
        |=> dst_reg == $past(dst_reg) + $past(step))
        else $error("destination pointer did not increment");

    AST_CNT_BYTE: assert property (s_step_plain ##0 !mode_reg[EDMAC_SIZE_BIT]
        && cnt_reg != EDMAC_RST_WORD |=> cnt_reg == $past(cnt_reg) - EDMAC_STEP_BYTE)
        else $error("byte transfer did not take one from the counter");

    AST_CNT_WORD: assert property (s_step_plain ##0 mode_reg[EDMAC_SIZE_BIT]
        && cnt_reg >= EDMAC_STEP_WORD |=> cnt_reg == $past(cnt_reg) - EDMAC_STEP_WORD)
        else $error("word transfer did not take two from the counter");

    AST_INACTIVE_IDLE: assert property (state_reg == EDMAC_IDLE
        && !mode_reg[EDMAC_ACT_BIT] |=> state_reg == EDMAC_IDLE && !rd_reg && !wr_reg)
        else $error("transfer began while inactive");

    AST_AUTO_START: assert property (state_reg == EDMAC_IDLE && mode_reg[EDMAC_ACT_BIT]
        && msel == EDMAC_MSEL_NORMAL && cnt_reg != EDMAC_RST_WORD
        |=> rd_reg && ext_bus_own && ext_addr == $past(src_reg))
        else $error("activated channel did not start reading");

    AST_READ_THEN_WRITE: assert property (s_read_done ##0 !single_addr
        |=> wr_reg && ext_addr == $past(dst_reg) ##0 !rd_reg)
        else $error("write did not follow read");

    AST_BUS_RELEASED: assert property (state_reg == EDMAC_STEP
        |-> !own_reg && !rd_reg && !wr_reg ##1 !own_reg)
        else $error("bus held past the transfer pair");

    AST_SINGLE_ADDR: assert property (s_read_done ##0 single_addr
        |=> state_reg == EDMAC_STEP && !wr_reg && !dack_reg)
        else $error("single address mode issued a write");

    AST_DONE_STOP: assert property (s_step_plain ##0 cnt_reg <= step
        |=> !mode_reg[EDMAC_ACT_BIT] && cnt_reg == EDMAC_RST_WORD ##1 state_reg == EDMAC_IDLE)
        else $error("channel did not stop at zero count");

endmodule : edmac_channel

`default_nettype wire

// File: core/edmac_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; first stage feeds only the second
module edmac_pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // Metastability filter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule : edmac_pin_sync

`default_nettype wire

// File: core/edmac_pkg.sv
package edmac_pkg;

    // Register indices; byte address is four times the index
    localparam logic [23:0] EDMAC_IDX_SRC  = 24'hFFFDE0;
    localparam logic [23:0] EDMAC_IDX_DST  = 24'hFFFDE4;
    localparam logic [23:0] EDMAC_IDX_CNT  = 24'hFFFDE8;
    localparam logic [23:0] EDMAC_IDX_MODE = 24'hFFFDEC;
    localparam logic [23:0] EDMAC_IDX_UPD  = 24'hFFFDEE;

    // Mode control field positions
    localparam int unsigned EDMAC_ACT_BIT    = 15;
    localparam int unsigned EDMAC_SINGLE_BIT = 10;
    localparam int unsigned EDMAC_MSEL_HI    = 9;
    localparam int unsigned EDMAC_MSEL_LO    = 8;
    localparam int unsigned EDMAC_SIZE_BIT   = 3;

    // Address update field positions
    localparam int unsigned EDMAC_SRCU_HI = 15;
    localparam int unsigned EDMAC_SRCU_LO = 14;
    localparam int unsigned EDMAC_DSTU_HI = 7;
    localparam int unsigned EDMAC_DSTU_LO = 6;

    // Writable bits; others read as zero
    localparam logic [15:0] EDMAC_MODE_MASK = 16'h8708;
    localparam logic [15:0] EDMAC_UPD_MASK  = 16'hC0C0;

    // Reset values
    localparam logic [31:0] EDMAC_RST_WORD = 32'h0000_0000;
    localparam logic [15:0] EDMAC_RST_HALF = 16'h0000;

    // Field encodings
    localparam logic [1:0] EDMAC_MSEL_NORMAL = 2'h0;
    localparam logic [1:0] EDMAC_UPD_INC     = 2'h2;
    localparam logic [1:0] EDMAC_UPD_DEC     = 2'h3;

    // Bytes moved per transfer
    localparam logic [31:0] EDMAC_STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] EDMAC_STEP_WORD = 32'h0000_0002;

    typedef enum logic [2:0] {
        EDMAC_IDLE,
        EDMAC_RD,
        EDMAC_RD_END,
        EDMAC_WR,
        EDMAC_WR_END,
        EDMAC_STEP
    } edmac_state_e;

    // Byte address of a register index
    function automatic logic [31:0] edmac_reg_addr(input logic [23:0] idx);
        return {6'h00, idx, 2'h0};
    endfunction : edmac_reg_addr

    // Pointer advance by update mode
    function automatic logic [31:0] edmac_next_addr(input logic [31:0] addr,
                                                    input logic [1:0]  upd,
                                                    input logic [31:0] step);
        if (upd == EDMAC_UPD_INC)
        begin
            return addr + step;
        end
        else if (upd == EDMAC_UPD_DEC)
        begin
            return addr - step;
        end
        return addr;
    endfunction : edmac_next_addr

endpackage : edmac_pkg

// File: verification/edmac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// External flash and SRAM, four-phase answer with adjustable wait
module edmac_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  slow_cycles,
    input  wire logic [31:0] ext_addr,
    input  wire logic [15:0] ext_wdata,
    input  wire logic        ext_rd,
    input  wire logic        ext_wr,
    output logic             ext_ack,
    output logic      [15:0] ext_rdata
);
    logic [3:0]  wait_cnt;
    logic [31:0] wr_addr_log[$];
    logic [15:0] wr_data_log[$];

    // Read data follows the address so the bench can predict it
    function automatic logic [15:0] pattern(input logic [31:0] a);
        return {~a[7:0], a[7:0] ^ 8'hA5};
    endfunction : pattern

    // Ack held until the request drops; idle data toggles so stale values never match
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_ack   <= 1'b0;
            ext_rdata <= 16'h0000;
            wait_cnt  <= 4'h0;
        end
        else if (ext_ack)
        begin
            if (!ext_rd && !ext_wr)
            begin
                ext_ack   <= 1'b0;
                ext_rdata <= ~ext_rdata;
            end
        end
        else if ((ext_rd || ext_wr) && wait_cnt >= slow_cycles)
        begin
            ext_ack  <= 1'b1;
            wait_cnt <= 4'h0;
            if (ext_rd)
                ext_rdata <= pattern(ext_addr);
            else
            begin
                ext_rdata <= ~ext_rdata;
                wr_addr_log.push_back(ext_addr);
                wr_data_log.push_back(ext_wdata);
            end
        end
        else
        begin
            ext_rdata <= ~ext_rdata;
            if (ext_rd || ext_wr)
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : edmac_mem_model

`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import edmac_pkg::*;

    localparam logic [31:0] SRC0 = 32'h0020_0000;
    localparam logic [31:0] DST0 = 32'h0040_0000;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, ext_addr, v;
    logic        ext_ack, ext_rd, ext_wr, ext_word, ext_bus_own, ext_dack;
    logic [15:0] ext_rdata, ext_wdata;
    logic [3:0]  slow_cycles;
    logic        rd_q, wr_q, saw_word;
    int          failures, n_compared, n_rd, n_wr, n_dack, n_bad;

    edmac_channel edmac_channel_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_ack(ext_ack),
        .ext_rdata(ext_rdata), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_word(ext_word),
        .ext_bus_own(ext_bus_own), .ext_dack(ext_dack));

    edmac_mem_model edmac_mem_model_i (.pclk(pclk), .presetn(presetn),
        .slow_cycles(slow_cycles), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_ack(ext_ack), .ext_rdata(ext_rdata));

    // 250 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Bus watcher: request starts, strobe cycles, overlap or unowned cycles
    always @(posedge pclk)
    begin
        if (ext_rd && !rd_q) n_rd++;
        if (ext_wr && !wr_q) n_wr++;
        if (ext_dack) n_dack++;
        if (ext_rd && ext_word) saw_word = 1'b1;
        if ((ext_rd && ext_wr) || ((ext_rd || ext_wr) && !ext_bus_own)) n_bad++;
        rd_q <= ext_rd;
        wr_q <= ext_wr;
    end

    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [23:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {6'h00, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 40)
        begin
            failures++;
            tally_and_finish();
        end
    endtask : apb

    task automatic wr_reg(input logic [23:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, idx, wd, rd, er);
    endtask : wr_reg

    task automatic rd_reg(input logic [23:0] idx, output logic [31:0] rd);
        logic er;
        apb(1'b0, idx, 32'h0, rd, er);
    endtask : rd_reg

    // Program the channel, then wait for the activation flag to drop or a fixed idle span
    task automatic run(input logic [31:0] mode, upd, cnt, input logic [3:0] slow, input bit runs);
        int n;
        slow_cycles <= slow;
        n_rd = 0;
        n_wr = 0;
        n_dack = 0;
        saw_word = 1'b0;
        edmac_mem_model_i.wr_addr_log.delete();
        edmac_mem_model_i.wr_data_log.delete();
        wr_reg(EDMAC_IDX_SRC, SRC0);
        wr_reg(EDMAC_IDX_DST, DST0);
        wr_reg(EDMAC_IDX_CNT, cnt);
        wr_reg(EDMAC_IDX_UPD, upd);
        wr_reg(EDMAC_IDX_MODE, mode);
        n = 0;
        if (runs)
        begin
            do
            begin
                rd_reg(EDMAC_IDX_MODE, v);
                n++;
            end
            while (v[15] !== 1'b0 && n < 200);
            if (n >= 200)
            begin
                failures++;
                tally_and_finish();
            end
        end
        else
            repeat (60) @(posedge pclk);
    endtask : run

    task automatic post(input logic [31:0] s, d, c, m, input int r, w);
        rd_reg(EDMAC_IDX_SRC, v);
        chk("source", v, s);
        rd_reg(EDMAC_IDX_DST, v);
        chk("destination", v, d);
        rd_reg(EDMAC_IDX_CNT, v);
        chk("counter", v, c);
        rd_reg(EDMAC_IDX_MODE, v);
        chk("mode", v, m);
        chk("reads", n_rd, r);
        chk("writes", n_wr, w);
    endtask : post

    // Each write lands at the next destination with the data read from the source
    task automatic log_chk(input int cnt, input int step, input logic [15:0] mask);
        for (int i = 0; i < cnt; i++)
        begin
            chk("write address", edmac_mem_model_i.wr_addr_log[i], DST0 + i * step);
            chk("write data", {16'h0, edmac_mem_model_i.wr_data_log[i] & mask},
                {16'h0, edmac_mem_model_i.pattern(SRC0 + i * step) & mask});
        end
    endtask : log_chk

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        slow_cycles = 4'h0;
        rd_q = 1'b0;
        wr_q = 1'b0;
        saw_word = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then unmapped accesses
        rd_reg(EDMAC_IDX_SRC, v);
        chk("source reset", v, EDMAC_RST_WORD);
        rd_reg(EDMAC_IDX_DST, v);
        chk("destination reset", v, EDMAC_RST_WORD);
        rd_reg(EDMAC_IDX_CNT, v);
        chk("counter reset", v, EDMAC_RST_WORD);
        rd_reg(EDMAC_IDX_MODE, v);
        chk("mode reset", v, {16'h0, EDMAC_RST_HALF});
        rd_reg(EDMAC_IDX_UPD, v);
        chk("update reset", v, {16'h0, EDMAC_RST_HALF});
        apb(1'b0, 24'hFFFDF0, 32'h0, v, err);
        chk("unmapped data", v, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, 24'hFFFDF4, 32'hFFFF_FFFF, v, err);
        chk("unmapped write error", {31'h0, err}, 32'h1);
        // Only documented fields hold written ones
        wr_reg(EDMAC_IDX_MODE, 32'h0000_7FF7);
        rd_reg(EDMAC_IDX_MODE, v);
        chk("mode fields", v, 32'h0000_0700);
        wr_reg(EDMAC_IDX_UPD, 32'hFFFF_FFFF);
        rd_reg(EDMAC_IDX_UPD, v);
        chk("update fields", v, 32'h0000_C0C0);
        wr_reg(EDMAC_IDX_MODE, 32'h0);
        // Dual address, byte, both pointers increment, prompt partner
        run(32'h8000, 32'h8080, 32'h3, 4'h0, 1'b1);
        post(SRC0 + 3, DST0 + 3, 32'h0, 32'h0, 3, 3);
        log_chk(3, 1, 16'h00FF);
        chk("strobe in dual", n_dack, 0);
        chk("byte access", {31'h0, saw_word}, 32'h0);
        // Word size, slow partner: counter drops by two per transfer
        run(32'h8008, 32'h8080, 32'h4, 4'h3, 1'b1);
        post(SRC0 + 4, DST0 + 4, 32'h0, 32'h8, 2, 2);
        log_chk(2, 2, 16'hFFFF);
        chk("word access", {31'h0, saw_word}, 32'h1);
        // Fixed pointers leave both addresses in place
        run(32'h8000, 32'h0000, 32'h2, 4'h1, 1'b1);
        post(SRC0, DST0, 32'h0, 32'h0, 2, 2);
        // Decrement code walks both pointers downwards
        run(32'h8000, 32'hC0C0, 32'h2, 4'h0, 1'b1);
        post(SRC0 - 2, DST0 - 2, 32'h0, 32'h0, 2, 2);
        // Single address: reads only, with the strobe
        run(32'h8400, 32'h8080, 32'h2, 4'h0, 1'b1);
        post(SRC0 + 2, DST0 + 2, 32'h0, 32'h400, 2, 0);
        chk("strobe in single", {31'h0, n_dack != 0}, 32'h1);
        // Inactive channel moves nothing
        run(32'h0000, 32'h8080, 32'h2, 4'h0, 1'b0);
        post(SRC0, DST0, 32'h2, 32'h0, 0, 0);
        // Mode select code 01 moves nothing either
        run(32'h8100, 32'h8080, 32'h2, 4'h0, 1'b0);
        post(SRC0, DST0, 32'h2, 32'h8100, 0, 0);
        // Reset in mid-transfer drops the bus and clears mode, counter and source
        wr_reg(EDMAC_IDX_CNT, 32'h40);
        wr_reg(EDMAC_IDX_MODE, 32'h8000);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk("bus own after reset", {31'h0, ext_bus_own}, 32'h0);
        rd_reg(EDMAC_IDX_MODE, v);
        chk("mode after reset", v, 32'h0);
        rd_reg(EDMAC_IDX_CNT, v);
        chk("counter after reset", v, 32'h0);
        rd_reg(EDMAC_IDX_SRC, v);
        chk("source after reset", v, 32'h0);
        wr_reg(EDMAC_IDX_MODE, 32'h0);
        chk("bus slips", n_bad, 0);
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
